// file: hw/asrt_map.vh
`ifndef ASRT_MAP_VH
`define ASRT_MAP_VH

// Register offsets on the three-bit register port.
`define ASRT_OFS_TX_STATUS_CONTROL 3'h0
`define ASRT_OFS_RX_STATUS_CONTROL 3'h1
`define ASRT_OFS_BAUD_DIVISOR 3'h2
`define ASRT_OFS_TX_HOLDING_BUFFER 3'h3
`define ASRT_OFS_PERIPH_FLAGS_ONE 3'h4
`define ASRT_OFS_PERIPH_ENABLES_ONE 3'h5
`define ASRT_OFS_INTERRUPT_CONTROL 3'h6

// Field positions of transmit_status_control.
`define ASRT_TX_CLOCK_SOURCE_BIT 7
`define ASRT_TX_NINE_BIT_SELECT_BIT 6
`define ASRT_TX_ENABLE_BIT 5
`define ASRT_TX_SYNC_SELECT_BIT 4
`define ASRT_TX_HIGH_SPEED_BIT 2
`define ASRT_TX_SHIFT_EMPTY_BIT 1
`define ASRT_TX_NINTH_BIT 0

// Field positions of receive_status_control.
`define ASRT_RX_PORT_ENABLE_BIT 7
`define ASRT_RX_NINE_BIT_SELECT_BIT 6
`define ASRT_RX_SINGLE_RECEIVE_BIT 5
`define ASRT_RX_CONT_RECEIVE_BIT 4
`define ASRT_RX_ADDRESS_DETECT_BIT 3

// Field positions of the flag, enable and interrupt control registers.
`define ASRT_TX_FLAG_BIT 4
`define ASRT_TX_IRQ_ENABLE_BIT 4
`define ASRT_GLOBAL_IRQ_ENABLE_BIT 7
`define ASRT_PERIPH_IRQ_ENABLE_BIT 6

// Reset values.
`define ASRT_RST_TX_STATUS_CONTROL 8'h02
`define ASRT_RST_RX_STATUS_CONTROL 8'h00
`define ASRT_RST_BAUD_DIVISOR 8'h00
`define ASRT_RST_TX_HOLDING_BUFFER 8'h00

// Last prescale counts; a baud generator step lasts this value plus one system clocks.
`define ASRT_PRESCALE_LOW_SPEED 6'h3F
`define ASRT_PRESCALE_HIGH_SPEED 6'h0F

// Frame lengths in bits, start and stop included.
`define ASRT_FRAME_BITS_EIGHT 4'hA
`define ASRT_FRAME_BITS_NINE 4'hB

`endif

// file: hw/asrt_baud.v
`timescale 1ns/1ps
`include "asrt_map.vh"

module asrt_baud #(
  parameter DIV_W = 8
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire run_i,
  input wire restart_i,
  input wire high_speed_i,
  input wire [DIV_W-1:0] divisor_i,
  output wire tick_o
);
  reg [5:0] pre_cnt;
  reg [DIV_W-1:0] div_cnt;
  wire [5:0] pre_last;
  wire pre_end;

  assign pre_last = high_speed_i ? `ASRT_PRESCALE_HIGH_SPEED :
                    `ASRT_PRESCALE_LOW_SPEED;
  assign pre_end = (pre_cnt == pre_last);
  // One tick every (divisor + 1) prescaled steps of the system clock.
  assign tick_o = run_i & ~restart_i & pre_end & (div_cnt == {DIV_W{1'b0}});

  always @(posedge clk_sys_i) begin
    if (rst_i || restart_i || !run_i) begin
      pre_cnt <= 6'h00;
      div_cnt <= divisor_i;
    end else if (pre_end) begin
      pre_cnt <= 6'h00;
      if (div_cnt == {DIV_W{1'b0}}) begin
        div_cnt <= divisor_i;
      end else begin
        div_cnt <= div_cnt - {{(DIV_W-1){1'b0}}, 1'b1};
      end
    end else begin
      pre_cnt <= pre_cnt + 6'h01;
    end
  end
endmodule

// file: hw/asrt_top.v
// Overview of operation
// - Idle line rests at mark, NRZ levels.
// - Frame: start, eight or nine data, stop.
// - Start bit space, stop bits mark.
// - Every bit lasts exactly one baud period.
// - Baud from 8-bit divisor generator.
// - Data bits sent least significant first.
// - Receiver not built; baud serves transmit alone.
// - No hardware parity; ninth bit carries it.
// - Active only when enabled, async, port on.
// - Port enable forces transmit pin output.
// - Port enable forces receive pin input.
// - Setting transmit enable raises empty flag.
// - Buffer write starts; idle shifter loads immediately.
// - Busy shifter: load right after stop bit.
// - Empty flag set unless character queued.
// - Empty flag valid from second cycle on.
// - Flag needs all three transmit enables; interrupt also needs its three.
// - Shift-empty clears on load, sets after shifting.
// - Nine-bit mode sends stored ninth bit last.
`timescale 1ns/1ps
`include "asrt_map.vh"

module asrt_top #(
  parameter DIV_W = 8,
  parameter DATA_W = 8
) (
  input wire CLK_SYS_I,
  input wire RST_I,
  input wire [2:0] ADDR_I,
  input wire [7:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output reg [7:0] RDATA_O,
  input wire TX_PIN_I,
  output wire TX_PIN_O,
  output wire TX_PIN_OE_O,
  input wire TX_PORT_LATCH_I,
  input wire TX_PORT_DIR_IN_I,
  input wire RX_PIN_I,
  output wire RX_PIN_O,
  output wire RX_PIN_OE_O,
  input wire RX_PORT_LATCH_I,
  input wire RX_PORT_DIR_IN_I,
  output reg [1:0] PIN_LEVEL_O,
  output wire IRQ_O
);
  // Two states suffice: the bit counter tracks the place in the frame.
  localparam ST_IDLE = 1'b0;
  localparam ST_SHIFT = 1'b1;

  // Software-written control bits. The receive-side bits are only stored
  // and read back, so software sees a complete register image.
  reg clock_source;
  reg nine_bit_transmit_select;
  reg transmit_enable;
  reg sync_select;
  reg baud_high_speed_select;
  reg transmit_ninth_bit;
  reg serial_port_enable;
  reg rx_nine_bit_select;
  reg rx_single_receive;
  reg rx_cont_receive;
  reg rx_address_detect;
  reg [DIV_W-1:0] baud_divisor;
  reg [DATA_W-1:0] transmit_holding_buffer;
  reg transmit_interrupt_enable;
  reg global_interrupt_enable;
  reg peripheral_interrupt_enable;

  // Transmit path state. The shifter holds a whole frame, start bit in
  // bit zero, and fills with ones from the top, so the line shows mark
  // once the last bit of a frame has gone.
  reg holding_full;
  reg holding_ninth;
  reg state;
  reg next_state;
  reg [DATA_W+2:0] transmit_shift_register;
  reg [DATA_W+2:0] next_shift;
  reg [3:0] bits_left;
  reg [3:0] next_bits_left;
  reg load_from_holding;
  reg baud_restart;

  wire tx_active;
  wire baud_tick;
  wire shift_register_empty;
  wire transmit_buffer_empty_flag;
  wire wr_holding;
  wire [7:0] tx_status_read;
  wire [7:0] rx_status_read;

  // Builds a whole frame for the shifter, start bit in bit zero.
  function [DATA_W+2:0] frame_of;
    input [DATA_W-1:0] data;
    input ninth;
    input nine_sel;
    begin
      frame_of = {1'b1, nine_sel ? ninth : 1'b1, data, 1'b0};
    end
  endfunction

  // Number of bit periods a frame occupies on the line.
  function [3:0] frame_len;
    input nine_sel;
    begin
      frame_len = nine_sel ? `ASRT_FRAME_BITS_NINE : `ASRT_FRAME_BITS_EIGHT;
    end
  endfunction

  // All transmit actions, the empty flag included, need all three
  // enables; dropping any one of them aborts a frame at once.
  assign tx_active = transmit_enable & ~sync_select &
                     serial_port_enable;
  assign wr_holding = WR_I & (ADDR_I == `ASRT_OFS_TX_HOLDING_BUFFER);

  // The receiver is not built here; its control bits are only held and
  // read back, and this one baud generator serves the transmitter alone.
  asrt_baud #(
    .DIV_W(DIV_W)
  ) u_baud (
    .clk_sys_i(CLK_SYS_I),
    .rst_i(RST_I),
    .run_i(tx_active),
    .restart_i(baud_restart),
    .high_speed_i(baud_high_speed_select),
    .divisor_i(baud_divisor),
    .tick_o(baud_tick)
  );

  // Register writes. The read-only bits, shifter-empty status and the
  // empty flag, have no write path, so software cannot disturb them.
  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      clock_source <= 1'b0;
      nine_bit_transmit_select <= 1'b0;
      transmit_enable <= 1'b0;
      sync_select <= 1'b0;
      baud_high_speed_select <= 1'b0;
      transmit_ninth_bit <= 1'b0;
      serial_port_enable <= 1'b0;
      rx_nine_bit_select <= 1'b0;
      rx_single_receive <= 1'b0;
      rx_cont_receive <= 1'b0;
      rx_address_detect <= 1'b0;
      baud_divisor <= `ASRT_RST_BAUD_DIVISOR;
      transmit_holding_buffer <= `ASRT_RST_TX_HOLDING_BUFFER;
      transmit_interrupt_enable <= 1'b0;
      global_interrupt_enable <= 1'b0;
      peripheral_interrupt_enable <= 1'b0;
    end else if (WR_I) begin
      case (ADDR_I)
        `ASRT_OFS_TX_STATUS_CONTROL: begin
          clock_source <= WDATA_I[`ASRT_TX_CLOCK_SOURCE_BIT];
          nine_bit_transmit_select <= WDATA_I[`ASRT_TX_NINE_BIT_SELECT_BIT];
          transmit_enable <= WDATA_I[`ASRT_TX_ENABLE_BIT];
          sync_select <= WDATA_I[`ASRT_TX_SYNC_SELECT_BIT];
          baud_high_speed_select <= WDATA_I[`ASRT_TX_HIGH_SPEED_BIT];
          transmit_ninth_bit <= WDATA_I[`ASRT_TX_NINTH_BIT];
        end
        `ASRT_OFS_RX_STATUS_CONTROL: begin
          serial_port_enable <= WDATA_I[`ASRT_RX_PORT_ENABLE_BIT];
          rx_nine_bit_select <= WDATA_I[`ASRT_RX_NINE_BIT_SELECT_BIT];
          rx_single_receive <= WDATA_I[`ASRT_RX_SINGLE_RECEIVE_BIT];
          rx_cont_receive <= WDATA_I[`ASRT_RX_CONT_RECEIVE_BIT];
          rx_address_detect <= WDATA_I[`ASRT_RX_ADDRESS_DETECT_BIT];
        end
        `ASRT_OFS_BAUD_DIVISOR: begin
          baud_divisor <= WDATA_I[DIV_W-1:0];
        end
        `ASRT_OFS_TX_HOLDING_BUFFER: begin
          transmit_holding_buffer <= WDATA_I[DATA_W-1:0];
        end
        `ASRT_OFS_PERIPH_ENABLES_ONE: begin
          transmit_interrupt_enable <= WDATA_I[`ASRT_TX_IRQ_ENABLE_BIT];
        end
        `ASRT_OFS_INTERRUPT_CONTROL: begin
          global_interrupt_enable <= WDATA_I[`ASRT_GLOBAL_IRQ_ENABLE_BIT];
          peripheral_interrupt_enable <= WDATA_I[`ASRT_PERIPH_IRQ_ENABLE_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // Shifter sequencing. The next frame is taken on the very tick that
  // ends the stop bit, so back-to-back frames leave no gap on the line.
  always @* begin
    next_state = state;
    next_shift = transmit_shift_register;
    next_bits_left = bits_left;
    load_from_holding = 1'b0;
    baud_restart = 1'b0;
    case (state)
      ST_IDLE: begin
        next_shift = {(DATA_W+3){1'b1}};
        if (tx_active && holding_full) begin
          load_from_holding = 1'b1;
          // Restart the divider so the start bit gets a full period.
          baud_restart = 1'b1;
          next_state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (baud_tick) begin
          // The last counted bit is the stop bit; its end is the only
          // point at which a queued character may move in.
          if (bits_left == 4'h1) begin
            if (holding_full) begin
              load_from_holding = 1'b1;
            end else begin
              next_state = ST_IDLE;
              next_shift = {(DATA_W+3){1'b1}};
            end
          end else begin
            next_shift = {1'b1, transmit_shift_register[DATA_W+2:1]};
            next_bits_left = bits_left - 4'h1;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (load_from_holding) begin
      next_shift = frame_of(transmit_holding_buffer, holding_ninth,
                            nine_bit_transmit_select);
      next_bits_left = frame_len(nine_bit_transmit_select);
    end
    // Losing an enable overrides everything above and drops the frame.
    if (!tx_active) begin
      next_state = ST_IDLE;
      next_shift = {(DATA_W+3){1'b1}};
    end
  end

  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      state <= ST_IDLE;
      transmit_shift_register <= {(DATA_W+3){1'b1}};
      bits_left <= 4'h0;
    end else begin
      state <= next_state;
      transmit_shift_register <= next_shift;
      bits_left <= next_bits_left;
    end
  end

  // Holding buffer occupancy. A write in the same cycle as a transfer
  // keeps the buffer full, so no character is lost. Disabling the
  // transmitter flushes it; nothing is queued while disabled. A second
  // write while a character waits replaces it, so software should
  // watch the empty flag before writing.
  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      holding_full <= 1'b0;
      holding_ninth <= 1'b0;
    end else if (!tx_active) begin
      holding_full <= 1'b0;
    end else if (wr_holding) begin
      holding_full <= 1'b1;
      holding_ninth <= transmit_ninth_bit;
    end else if (load_from_holding) begin
      holding_full <= 1'b0;
    end
  end

  // The empty flag follows buffer state and the three enables, and is never written by
  // software. It settles one cycle after the buffer write, and dips for
  // one cycle when an idle shifter takes the character at once, so a
  // poll straight after a write may read a stale value.
  assign transmit_buffer_empty_flag = tx_active &
                                      ~holding_full;
  assign shift_register_empty = (state == ST_IDLE);
  // The request is a level: it stays up while the buffer is empty and
  // all three enables are set, so software must clear an enable to stop.
  assign IRQ_O = transmit_buffer_empty_flag & transmit_interrupt_enable &
                 peripheral_interrupt_enable &
                 global_interrupt_enable;

  // Pin steering. The port latch reaches a pin only while the serial
  // port is off; the direction input is active high for input.
  // A set direction bit does not stop the port enable driving the pin.
  assign TX_PIN_O = serial_port_enable ? transmit_shift_register[0] :
                    TX_PORT_LATCH_I;
  assign TX_PIN_OE_O = serial_port_enable | ~TX_PORT_DIR_IN_I;
  assign RX_PIN_O = RX_PORT_LATCH_I;
  assign RX_PIN_OE_O = ~serial_port_enable & ~RX_PORT_DIR_IN_I;

  // Pin levels stay readable in every mode.
  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      PIN_LEVEL_O <= 2'h3;
    end else begin
      PIN_LEVEL_O <= {RX_PIN_I, TX_PIN_I};
    end
  end

  // Register reads. Parity has no bit anywhere; software computes it
  // and places it in the ninth data bit.
  // Unmapped offsets and the write-only holding buffer read as zero.
  assign tx_status_read = {clock_source, nine_bit_transmit_select,
                           transmit_enable, sync_select, 1'b0,
                           baud_high_speed_select, shift_register_empty,
                           transmit_ninth_bit};
  assign rx_status_read = {serial_port_enable, rx_nine_bit_select,
                           rx_single_receive, rx_cont_receive,
                           rx_address_detect, 3'h0};

  always @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      RDATA_O <= 8'h00;
    end else if (RD_I) begin
      case (ADDR_I)
        `ASRT_OFS_TX_STATUS_CONTROL: begin
          RDATA_O <= tx_status_read;
        end
        `ASRT_OFS_RX_STATUS_CONTROL: begin
          RDATA_O <= rx_status_read;
        end
        `ASRT_OFS_BAUD_DIVISOR: begin
          RDATA_O <= baud_divisor;
        end
        `ASRT_OFS_PERIPH_FLAGS_ONE: begin
          RDATA_O <= {3'h0, transmit_buffer_empty_flag, 4'h0};
        end
        `ASRT_OFS_PERIPH_ENABLES_ONE: begin
          RDATA_O <= {3'h0, transmit_interrupt_enable, 4'h0};
        end
        `ASRT_OFS_INTERRUPT_CONTROL: begin
          RDATA_O <= {global_interrupt_enable,
                      peripheral_interrupt_enable, 6'h00};
        end
        default: begin
          RDATA_O <= 8'h00;
        end
      endcase
    end else begin
      // Read data stand for one cycle only; idle cycles return zero.
      RDATA_O <= 8'h00;
    end
  end
endmodule

// file: bench/asrt_top_monitor.sv
`timescale 1ns/1ps
module asrt_top_monitor (
  input wire CLK_SYS_I,
  input wire RST_I,
  input wire [2:0] ADDR_I,
  input wire [7:0] WDATA_I,
  input wire WR_I,
  input wire TX_PIN_O,
  input wire TX_PIN_OE_O,
  input wire TX_PORT_DIR_IN_I,
  input wire RX_PIN_OE_O,
  input wire RX_PORT_DIR_IN_I,
  input wire IRQ_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  // The shortest baud period is sixteen clocks, so eight is a safe floor.
  chk_low_len: assert property ($fell(TX_PIN_O) |=> !TX_PIN_O [*8])
    else $error("low level shorter than one bit");
  chk_high_len: assert property ($rose(TX_PIN_O) |=> TX_PIN_O [*8])
    else $error("high level shorter than one bit");
  chk_reset_idle: assert property ($past(RST_I) |->
    TX_PIN_O && (TX_PIN_OE_O == !TX_PORT_DIR_IN_I))
    else $error("pin not released to the port after reset");
  chk_port_pins: assert property (WR_I && ADDR_I == 3'h1 &&
    WDATA_I[7] |=> TX_PIN_OE_O && !RX_PIN_OE_O)
    else $error("port enable did not take over the pins");
  chk_rx_input: assert property (RX_PORT_DIR_IN_I |-> !RX_PIN_OE_O)
    else $error("receive pin driven while set as input");
  chk_gie_off: assert property (WR_I && ADDR_I == 3'h6 &&
    !WDATA_I[7] |=> !IRQ_O)
    else $error("interrupt without global enable");
  chk_transmit_interrupt_enable_off: assert property (WR_I && ADDR_I == 3'h5 &&
    !WDATA_I[4] |=> !IRQ_O)
    else $error("interrupt without transmit enable");
  chk_transmit_enable_off: assert property (WR_I && ADDR_I == 3'h0 &&
    !WDATA_I[5] |=> !IRQ_O)
    else $error("empty flag kept while transmitter off");
endmodule

// file: bench/asrt_rx_model.sv
`timescale 1ns/1ps
module asrt_rx_model (
  input wire clk_i,
  input wire line_i,
  input wire nine_i,
  input wire [15:0] bit_clks_i,
  output reg got_o = 1'b0,
  output reg [8:0] word_o = 9'h000,
  output reg stop_ok_o = 1'b0
);
  integer i;
  // Sampling mid-bit tolerates the one-clock skew of the launching edge.
  initial begin
    forever begin
      @(negedge line_i);
      repeat (bit_clks_i / 2) @(posedge clk_i);
      if (line_i === 1'b0) begin
        word_o = 9'h000;
        for (i = 0; i < (nine_i ? 9 : 8); i = i + 1) begin
          repeat (bit_clks_i) @(posedge clk_i);
          word_o[i] = line_i;
        end
        repeat (bit_clks_i) @(posedge clk_i);
        stop_ok_o = line_i;
        got_o = 1'b1;
        @(posedge clk_i);
        got_o = 1'b0;
      end
    end
  end
endmodule

// file: bench/asrt_top_tb.sv
`timescale 1ns/1ps
module asrt_top_tb;
  reg clk_sys = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  reg tx_dir_in = 1'b1, rx_dir_in = 1'b1, rx_pin = 1'b1;
  reg nine = 1'b0, hs = 1'b1, tx_latch = 1'b1, rx_latch = 1'b1;
  reg [2:0] addr = 3'h0;
  reg [7:0] wdata = 8'h00, rv;
  wire [7:0] rdata;
  wire tx_pin, tx_oe, rx_oe, irq, got, stop_ok, rx_out;
  wire [1:0] pin_lvl;
  wire [8:0] word;
  integer err_count = 0, check_count = 0, b = 32, n, k;
  reg [8:0] exp_q[$];
  always #5 clk_sys = ~clk_sys;
  asrt_top dut (.CLK_SYS_I(clk_sys), .RST_I(rst), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .TX_PIN_I(tx_pin), .TX_PIN_O(tx_pin), .TX_PIN_OE_O(tx_oe),
    .TX_PORT_LATCH_I(tx_latch), .TX_PORT_DIR_IN_I(tx_dir_in),
    .RX_PIN_I(rx_pin), .RX_PIN_O(rx_out), .RX_PIN_OE_O(rx_oe),
    .RX_PORT_LATCH_I(rx_latch), .RX_PORT_DIR_IN_I(rx_dir_in),
    .PIN_LEVEL_O(pin_lvl), .IRQ_O(irq));
  asrt_rx_model peer (.clk_i(clk_sys), .line_i(tx_pin), .nine_i(nine),
    .bit_clks_i(b[15:0]), .got_o(got), .word_o(word), .stop_ok_o(stop_ok));
  task check(input string nm, input [15:0] seen, input [15:0] expv);
    begin
      check_count = check_count + 1;
      if (seen !== expv) begin
        err_count = err_count + 1;
        $display("[ERR] %s expected %h seen %h", nm, expv, seen);
      end
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // The idle cycle at the end keeps back-to-back calls from reassigning
  // a strobe twice in one time step.
  task wr_reg(input [2:0] a, input [7:0] d);
    begin
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task rd_reg(input [2:0] a);
    begin
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1 rv = rdata;
      @(posedge clk_sys);
    end
  endtask
  task send(input [8:0] w);
    begin
      wr_reg(3'h0, {1'b0, nine, 3'h4, hs, 1'b0, w[8]});
      wr_reg(3'h3, w[7:0]);
      exp_q.push_back(nine ? w : {1'b0, w[7:0]});
    end
  endtask
  task drain;
    begin
      n = 0;
      while (exp_q.size() != 0 && n < 20000) begin
        @(posedge clk_sys);
        n = n + 1;
      end
      check("drained", exp_q.size(), 16'h0000);
      repeat (b) @(posedge clk_sys);
      rd_reg(3'h0);
      check("shift_empty", rv[1], 1'b1);
    end
  endtask
  // The start bit is already on the line when send returns.
  task low_run(input integer bits);
    begin
      #1 k = 0;
      while (tx_pin === 1'b0 && k < 2000) begin
        @(posedge clk_sys);
        #1 k = k + 1;
      end
      check("low_run", k, bits * b);
      @(posedge clk_sys);
    end
  endtask
  always @(negedge clk_sys) begin
    if (got === 1'b1) begin
      check("word", word, exp_q.pop_front());
      check("stop_bit", stop_ok, 1'b1);
    end
  end
  initial begin
    n = $urandom(32'hB950ED6D);
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd_reg(3'h0);
    check("tx_ctrl_rst", rv, 8'h02);
    rd_reg(3'h2);
    check("divisor_rst", rv, 8'h00);
    rd_reg(3'h4);
    check("flag_off", rv, 8'h00);
    rd_reg(3'h7);
    check("unmapped", rv, 8'h00);
    rx_dir_in <= 1'b0;
    rx_pin <= $urandom;
    rx_latch <= $urandom;
    wr_reg(3'h2, 8'h01);
    check("rx_oe_port", rx_oe, 1'b1);
    check("rx_out_port", rx_out, rx_latch);
    check("tx_oe_port", tx_oe, 1'b0);
    check("pin_level", pin_lvl, {rx_pin, tx_pin});
    wr_reg(3'h1, 8'h80);
    tx_latch <= 1'b0;
    check("tx_oe", tx_oe, 1'b1);
    check("rx_oe", rx_oe, 1'b0);
    wr_reg(3'h0, 8'h24);
    rd_reg(3'h4);
    check("flag_on", rv, 8'h10);
    wr_reg(3'h6, 8'hC0);
    wr_reg(3'h5, 8'h10);
    check("irq_on", irq, 1'b1);
    wr_reg(3'h5, 8'h00);
    check("irq_off", irq, 1'b0);
    $display("test registers done");
    wr_reg(3'h5, 8'h10);
    rv = $urandom;
    send({1'b0, rv});
    rv = $urandom;
    send({1'b0, rv});
    check("irq_queued", irq, 1'b0);
    wr_reg(3'h5, 8'h00);
    rd_reg(3'h4);
    check("flag_queued", rv, 8'h00);
    rd_reg(3'h0);
    check("shift_busy", rv[1], 1'b0);
    drain;
    rd_reg(3'h4);
    check("flag_back", rv, 8'h10);
    send(9'h000);
    low_run(9);
    drain;
    $display("test eight bit done");
    nine = 1'b1;
    hs = 1'b0;
    b = 64;
    wr_reg(3'h2, 8'h00);
    send(9'h000);
    low_run(10);
    drain;
    send({1'b1, 8'hA5});
    drain;
    $display("test nine bit done");
    wr_reg(3'h0, 8'h34);
    rd_reg(3'h4);
    check("flag_sync", rv, 8'h00);
    wr_reg(3'h3, 8'h3C);
    repeat (200) @(posedge clk_sys);
    check("sync_idle", tx_pin, 1'b1);
    rd_reg(3'h0);
    check("sync_empty", rv[1], 1'b1);
    wr_reg(3'h0, 8'h00);
    rd_reg(3'h4);
    check("flag_dis", rv, 8'h00);
    wr_reg(3'h3, 8'h3C);
    repeat (200) @(posedge clk_sys);
    check("line_idle", tx_pin, 1'b1);
    wr_reg(3'h6, 8'h00);
    $display("test disable done");
    end_sim;
  end
  initial begin
    #800000;
    err_count = err_count + 1;
    end_sim;
  end
endmodule
bind asrt_top asrt_top_monitor mon (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I),
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .TX_PIN_O(TX_PIN_O),
  .TX_PIN_OE_O(TX_PIN_OE_O), .TX_PORT_DIR_IN_I(TX_PORT_DIR_IN_I),
  .RX_PIN_OE_O(RX_PIN_OE_O), .RX_PORT_DIR_IN_I(RX_PORT_DIR_IN_I),
  .IRQ_O(IRQ_O));
